//--- include/asfc_pkg.sv
// Shared types and constants for the serial frame and state control block.
package asfc_pkg;
  // Pin group sampled from outside the clock domain.
  typedef struct packed {
    logic cs;
    logic sclk;
    logic serial_input_pin;
    logic rst_n;
  } asfc_pins_t;

  typedef enum logic [1:0] {
    ST_RESET,
    ST_ACQ,
    ST_CONV,
    ST_STANDBY
  } asfc_state_t;

  localparam int CLK_PERIOD_NS = 40;
  localparam int FRAME_BITS = 32;
  localparam int SHORT_WRITE_BITS = 16;
  localparam logic [6:0] CNT_FULL = 7'h20;
  localparam logic [6:0] CNT_HALF = 7'h10;
  localparam logic [6:0] CNT_MAX = 7'h7f;
  localparam logic [31:0] CMD_NOP = 32'h0000_0000;
  localparam logic [15:0] CMD_STANDBY = 16'h8200;
  localparam logic [15:0] STATUS_FILL = 16'h0000;
  localparam logic [31:0] INVALID_WORD = 32'hffff_ffff;
  // Conversion time rounds up; reset delays are least times and round up too.
  localparam int T_CONV_NS = 700;
  localparam int T_D_RST_APP_NS = 1000;
  localparam int T_D_RST_POR_NS = 20000;
  localparam int CONV_CYC = (T_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int APP_CYC = (T_D_RST_APP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_CYC = (T_D_RST_POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] CONV_LAST = 10'(CONV_CYC - 1);
  localparam logic [9:0] APP_LAST = 10'(APP_CYC - 1);
  localparam logic [9:0] POR_LAST = 10'(POR_CYC - 1);
endpackage

//--- design/asfc_pin_sync.sv
// Two-stage synchroniser for the serial pins, with a delayed copy for edges.
`timescale 1ns/1ps
module asfc_pin_sync
  import asfc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Raw pins
  input wire asfc_pins_t pins_in,
  // Synchronised pins and their previous value
  output asfc_pins_t sync_out,
  output asfc_pins_t prev_out
);
  asfc_pins_t meta;

  // Idle levels: select high, clock low, reset pin released.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta <= '{cs: 1'b1, sclk: 1'b0, serial_input_pin: 1'b0, rst_n: 1'b1};
      sync_out <= '{cs: 1'b1, sclk: 1'b0, serial_input_pin: 1'b0, rst_n: 1'b1};
      prev_out <= '{cs: 1'b1, sclk: 1'b0, serial_input_pin: 1'b0, rst_n: 1'b1};
    end else begin
      meta <= pins_in;
      sync_out <= meta;
      prev_out <= sync_out;
    end
  end
endmodule

//--- design/asfc_frame_ctrl.sv
// Serial frame shifter, command capture and operating state sequencer.
//
// Operation
// - Chain transfers are clocked by host serial clock, legacy protocol.
// - Analog input is sampled on the select rising edge.
// - Clock rise drives register MSB out; clock fall shifts input into LSB.
// - Host receives last device word first, each word MSB first.
// - On select rise the shifted word is decoded and acted upon.
// - Four states, reset, acquisition, conversion, standby, chosen by select and reset pin.
// - Reset pin acts asynchronously and must be held low minimum time; here it is synchronised and acted on at its sampled fall.
// - Application reset restores defaults, holds ready low, releases outputs.
// - Default reset pin action is power-on reset with settling delay.
// - Leave reset with select high and clock low; after delay enter acquisition, ready high.
// - Acquisition entered at power-up, after reset, after conversion; nap offered.
// - Acquisition goes to reset on pin fall, to conversion on select rise.
// - Conversion ignores select transitions until conversion time elapses.
// - Valid standby word takes effect at the next select rise.
// - Standby holds while no conversion command and serial input stays low.
// - In standby 16-clock writes are accepted; 32-clock frames return invalid data.
// - Frame runs from select fall to the next rise, where conversion starts.
// - Select fall clears counter, loads output word, resets command to no-op.
// - 32 or more clocks is a valid command; shorter frames discard the write, except 16-clock writes in standby.
`timescale 1ns/1ps
module asfc_frame_ctrl
  import asfc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Serial pins from the host
  input wire logic convert_start_chip_select_in,
  input wire logic sclk_in,
  input wire logic serial_input_pin_in,
  input wire logic reset_pin_n_in,
  // Configuration and converter result
  input wire logic application_reset_select_in,
  input wire logic low_power_nap_in,
  input wire logic [15:0] conv_result_in,
  // Serial output pin and ready strobe
  output logic primary_serial_output_out,
  output logic primary_serial_output_oe_out,
  output logic ready_strobe_out,
  // Core side
  output logic sample_strobe_out,
  output logic cmd_valid_out,
  output logic [31:0] cmd_word_out,
  output logic app_reset_out,
  output logic por_reset_out,
  output logic nap_out,
  output asfc_state_t state_out
);
  asfc_pins_t raw;
  asfc_pins_t pin;
  asfc_pins_t pin_q;
  asfc_state_t st;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic rst_fall;
  logic in_frame;
  logic sdi_seen;
  logic app_sel;
  logic [31:0] output_shift_register;
  logic [6:0] bit_cnt;
  logic [9:0] tmr;
  logic [31:0] next_word;
  logic word_ok;
  logic std_frame;

  assign raw = '{cs: convert_start_chip_select_in, sclk: sclk_in,
                 serial_input_pin: serial_input_pin_in, rst_n: reset_pin_n_in};

  asfc_pin_sync asfc_pin_sync_i (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .pins_in(raw),
    .sync_out(pin),
    .prev_out(pin_q)
  );

  // Edges are found on the synchronised copies; the link clock is slow enough.
  assign cs_fall = pin_q.cs & ~pin.cs;
  assign cs_rise = ~pin_q.cs & pin.cs;
  assign sclk_rise = ~pin_q.sclk & pin.sclk;
  assign sclk_fall = pin_q.sclk & ~pin.sclk;
  assign rst_fall = pin_q.rst_n & ~pin.rst_n;
  assign std_frame = st == ST_STANDBY;

  // Word handed to the decoder; a 16-clock standby write sits in the high half.
  always_comb begin
    next_word = output_shift_register;
    word_ok = 1'b0;
    // Longer frames keep the last 32 bits, so a chain can be programmed in one frame.
    // A select rise with no frame behind it must not replay the previous word.
    if (in_frame && bit_cnt >= CNT_FULL) begin
      word_ok = 1'b1;
    end else if (in_frame && std_frame && bit_cnt == CNT_HALF) begin
      next_word = {output_shift_register[15:0], STATUS_FILL};
      word_ok = 1'b1;
    end
  end

  // Operating state sequencing.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= ST_ACQ;
      tmr <= 10'h000;
    end else if (rst_fall) begin
      st <= ST_RESET;
      tmr <= 10'h000;
    end else begin
      case (st)
        ST_RESET: begin
          // Release only while select stays high and clock stays low.
          if (!pin.rst_n || !pin.cs || pin.sclk) begin
            tmr <= 10'h000;
          end else if (tmr == (app_sel ? APP_LAST : POR_LAST)) begin
            st <= ST_ACQ;
            tmr <= 10'h000;
          end else begin
            tmr <= tmr + 10'h001;
          end
        end
        ST_ACQ: begin
          if (cs_rise) begin
            st <= (word_ok && next_word[31:16] == CMD_STANDBY) ? ST_STANDBY : ST_CONV;
            tmr <= 10'h000;
          end
        end
        ST_CONV: begin
          // Select edges are not looked at here until the time is up.
          if (tmr == CONV_LAST) begin
            st <= ST_ACQ;
            tmr <= 10'h000;
          end else begin
            tmr <= tmr + 10'h001;
          end
        end
        ST_STANDBY: begin
          if (cs_rise && sdi_seen) begin
            st <= ST_CONV;
            tmr <= 10'h000;
          end
        end
        default: begin
          st <= ST_ACQ;
          tmr <= 10'h000;
        end
      endcase
    end
  end

  // Reset kind is caught at the pin fall from the configuration bit.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      app_sel <= 1'b0;
      app_reset_out <= 1'b0;
      por_reset_out <= 1'b0;
    end else begin
      app_reset_out <= rst_fall & application_reset_select_in;
      por_reset_out <= rst_fall & ~application_reset_select_in;
      if (rst_fall) begin
        app_sel <= application_reset_select_in;
      end
    end
  end

  // Frame tracking and the 32-bit shift path.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      in_frame <= 1'b0;
      sdi_seen <= 1'b0;
      bit_cnt <= 7'h00;
      output_shift_register <= CMD_NOP;
    end else if (rst_fall || st == ST_RESET || st == ST_CONV) begin
      in_frame <= 1'b0;
      sdi_seen <= 1'b0;
    end else if (cs_fall) begin
      in_frame <= 1'b1;
      sdi_seen <= 1'b0;
      bit_cnt <= 7'h00;
      output_shift_register <= std_frame ? INVALID_WORD : {conv_result_in, STATUS_FILL};
    end else if (cs_rise) begin
      in_frame <= 1'b0;
    end else if (in_frame && sclk_fall) begin
      output_shift_register <= {output_shift_register[30:0], pin.serial_input_pin};
      if (bit_cnt != CNT_MAX) begin
        bit_cnt <= bit_cnt + 7'h01;
      end
      if (pin.serial_input_pin) begin
        sdi_seen <= 1'b1;
      end
    end
  end

  // Serial output pin and ready strobe.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      primary_serial_output_out <= 1'b0;
      primary_serial_output_oe_out <= 1'b0;
      ready_strobe_out <= 1'b1;
    end else if (rst_fall || st == ST_RESET) begin
      primary_serial_output_oe_out <= 1'b0;
      if (st == ST_RESET && pin.rst_n && pin.cs && !pin.sclk &&
          tmr == (app_sel ? APP_LAST : POR_LAST)) begin
        ready_strobe_out <= 1'b1;
      end else begin
        ready_strobe_out <= 1'b0;
      end
    end else if (st == ST_CONV) begin
      primary_serial_output_oe_out <= 1'b0;
      if (tmr == CONV_LAST) begin
        ready_strobe_out <= 1'b1;
      end
    end else if (cs_fall) begin
      ready_strobe_out <= 1'b0;
      primary_serial_output_oe_out <= 1'b1;
    end else if (cs_rise) begin
      primary_serial_output_oe_out <= 1'b0;
      // A standby frame with serial input kept low starts no conversion, so ready returns at once.
      ready_strobe_out <= std_frame && !sdi_seen;
    end else if (in_frame && sclk_rise) begin
      primary_serial_output_out <= output_shift_register[31];
    end
  end

  // Command capture, analog sample strobe and nap.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_valid_out <= 1'b0;
      cmd_word_out <= CMD_NOP;
      sample_strobe_out <= 1'b0;
      nap_out <= 1'b0;
    end else begin
      cmd_valid_out <= 1'b0;
      sample_strobe_out <= 1'b0;
      nap_out <= st == ST_ACQ && low_power_nap_in && !in_frame;
      if (rst_fall || st == ST_RESET) begin
        cmd_word_out <= CMD_NOP;
      end else if (cs_fall && st != ST_CONV) begin
        cmd_word_out <= CMD_NOP;
      end else if (cs_rise && (st == ST_ACQ || st == ST_STANDBY)) begin
        sample_strobe_out <= st == ST_ACQ || sdi_seen;
        if (word_ok) begin
          cmd_valid_out <= 1'b1;
          cmd_word_out <= next_word;
        end
      end
    end
  end

  assign state_out = st;

  a_ready_frame_low:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cs_fall && (st == ST_ACQ || st == ST_STANDBY) && !rst_fall |=> !ready_strobe_out)
    else $error("ready not low after select fall");

  a_reset_out_off:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    st == ST_RESET |-> !primary_serial_output_oe_out)
    else $error("serial output driven in reset");

  a_conv_hold_time:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $rose(st == ST_CONV) |-> (st == ST_CONV || st == ST_RESET)[*8])
    else $error("conversion ended early");

  a_sample_on_rise:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cs_rise && st == ST_ACQ && !rst_fall |=> sample_strobe_out && st != ST_ACQ)
    else $error("no sample or state change on select rise");

  a_shift_launch:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    in_frame && sclk_rise && !cs_rise && !rst_fall && st != ST_RESET && st != ST_CONV
    |=> primary_serial_output_out == $past(output_shift_register[31]))
    else $error("output bit is not the register msb");

  a_shift_capture:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    in_frame && sclk_fall && !cs_rise && !cs_fall && !rst_fall
    && (st == ST_ACQ || st == ST_STANDBY)
    |=> output_shift_register[0] == $past(pin.serial_input_pin) && output_shift_register[31:1] == $past(output_shift_register[30:0]))
    else $error("shift path broken");

  a_valid_len:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cmd_valid_out |-> $past(in_frame) && ($past(bit_cnt) >= CNT_FULL
    || ($past(st) == ST_STANDBY && $past(bit_cnt) == CNT_HALF)))
    else $error("command taken from wrong frame length");

  a_standby_entry:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    st == ST_ACQ && in_frame && cs_rise && !rst_fall && bit_cnt == CNT_FULL
    && output_shift_register[31:16] == CMD_STANDBY |=> st == ST_STANDBY)
    else $error("standby word not honoured");

  a_acq_ready:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $rose(st == ST_ACQ) |-> ready_strobe_out)
    else $error("ready low on entering acquisition");

  a_output_timing:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    primary_serial_output_oe_out |-> in_frame || $past(cs_fall))
    else $error("output driven outside a frame");

  a_conv_end_ready:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    st == ST_CONV && tmr == CONV_LAST && !rst_fall |=> st == ST_ACQ && ready_strobe_out)
    else $error("conversion end did not return to acquisition");

  a_conv_ignore_cs:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    st == ST_CONV && tmr != CONV_LAST && !rst_fall |=> st == ST_CONV)
    else $error("conversion left before its time");

  a_pin_fall_reset:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    rst_fall |=> st == ST_RESET && !ready_strobe_out && !primary_serial_output_oe_out)
    else $error("reset pin fall not honoured");

  a_reset_kind:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    rst_fall |=> app_reset_out == $past(application_reset_select_in)
    && por_reset_out == !$past(application_reset_select_in))
    else $error("wrong reset kind pulsed");

  a_reset_wait:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    st == ST_RESET && tmr != (app_sel ? APP_LAST : POR_LAST) && !rst_fall |=> st == ST_RESET)
    else $error("reset left before its delay");

  a_frame_start:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cs_fall && (st == ST_ACQ || st == ST_STANDBY) && !rst_fall
    |=> bit_cnt == 7'h00 && cmd_word_out == CMD_NOP)
    else $error("frame start did not clear count and command");

  a_standby_hold:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    st == ST_STANDBY && cs_rise && !sdi_seen && !rst_fall |=> st == ST_STANDBY)
    else $error("standby left without a conversion request");

  a_standby_data:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cs_fall && st == ST_STANDBY && !rst_fall |=> output_shift_register == INVALID_WORD)
    else $error("standby frame not loaded with invalid data");

  // Outputs come from flops except the state view, which is the state register.
  // The chain behaviour of other devices and host spacing are the host's part.
endmodule

//--- bench/asfc_host_model.sv
// Host controller model that drives select, serial clock, data and reset pin.
`timescale 1ns/1ps
module asfc_host_model (
  // Pins toward the device
  output logic cs_out,
  output logic sclk_out,
  output logic sdi_out,
  output logic rst_n_out,
  // Pins from the device
  input wire logic sdo_in,
  input wire logic oe_in
);
  logic [63:0] rx;

  initial begin
    cs_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
    rst_n_out = 1'b1;
    rx = '0;
  end

  // The clock stands low outside frames, and data in is read just before the next launch.
  task automatic frame(input int n, input logic [63:0] tx);
    rx = '0;
    cs_out = 1'b0;
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_out = tx[i];
      #40 sclk_out = 1'b1;
      #160 sclk_out = 1'b0;
      #120 rx = {rx[62:0], oe_in ? sdo_in : 1'bx};
    end
    #40 cs_out = 1'b1;
    sdi_out = ~sdi_out;
  endtask

  task automatic cs_blip(input int ns);
    cs_out = 1'b0;
    #ns cs_out = 1'b1;
  endtask

  // Leaving reset keeps select idle and the clock low.
  task automatic set_rst(input logic v);
    rst_n_out = v;
  endtask
endmodule

//--- bench/asfc_frame_ctrl_tb_top.sv
// Self-checking testbench for the serial frame and state control block.
`timescale 1ns/1ps
module asfc_frame_ctrl_tb_top;
  import asfc_pkg::*;
  logic ref_clk_in, rst_in, cs, sclk, serial_input_pin, rst_n, app_sel, nap_en;
  logic sdo, oe, ready, sample, cmd_valid, app_rst, por_rst, low_power_nap;
  logic [15:0] result;
  logic [31:0] cmd_word, last_cmd;
  asfc_state_t state;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int n_cmd = 0;
  int n_smp = 0;
  int n_app = 0;
  int n_por = 0;

  asfc_frame_ctrl asfc_frame_ctrl_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .convert_start_chip_select_in(cs), .sclk_in(sclk), .serial_input_pin_in(serial_input_pin),
    .reset_pin_n_in(rst_n), .application_reset_select_in(app_sel),
    .low_power_nap_in(nap_en), .conv_result_in(result), .primary_serial_output_out(sdo),
    .primary_serial_output_oe_out(oe), .ready_strobe_out(ready), .sample_strobe_out(sample),
    .cmd_valid_out(cmd_valid), .cmd_word_out(cmd_word), .app_reset_out(app_rst),
    .por_reset_out(por_rst), .nap_out(low_power_nap), .state_out(state));

  asfc_host_model asfc_host_model_i (.cs_out(cs), .sclk_out(sclk), .sdi_out(serial_input_pin),
    .rst_n_out(rst_n), .sdo_in(sdo), .oe_in(oe));

  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    n_smp <= n_smp + (sample === 1'b1);
    n_app <= n_app + (app_rst === 1'b1);
    n_por <= n_por + (por_rst === 1'b1);
    n_cmd <= n_cmd + (cmd_valid === 1'b1);
    if (cmd_valid === 1'b1) begin
      last_cmd <= cmd_word;
    end
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end

  task automatic cmp_word(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_state(input string what, input asfc_state_t exp, input asfc_state_t got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  // Bounded wait, so a ready strobe that never rises is reported instead of hanging.
  task automatic wait_ready();
    int k;
    k = 0;
    while (ready !== 1'b1 && k < 40) begin
      tick(1);
      k++;
    end
    cmp_word("ready", 1, ready);
    cmp_state("acq", ST_ACQ, state);
  endtask

  task automatic t_full();
    int s;
    int c;
    s = n_smp;
    c = n_cmd;
    result = 16'h3c5a;
    asfc_host_model_i.frame(32, 64'h1234_5678);
    cmp_word("sdo", {32'h0, 16'h3c5a, 16'h0}, asfc_host_model_i.rx);
    tick(5);
    cmp_state("conv", ST_CONV, state);
    cmp_word("oe", 0, oe);
    cmp_word("cmd", 32'h1234_5678, last_cmd);
    // Select falls inside the conversion and rises after it: no frame, no command.
    asfc_host_model_i.cs_blip(800);
    tick(3);
    cmp_state("late rise", ST_CONV, state);
    wait_ready();
    tick(6);
    cmp_word("samples", s + 2, n_smp);
    cmp_word("no stale cmd", c + 1, n_cmd);
    cmp_word("idle oe", 0, oe);
    $display("test full frame done");
  endtask

  task automatic t_short_long();
    int c;
    c = n_cmd;
    result = 16'hc33c;
    asfc_host_model_i.frame(20, 64'h0);
    cmp_word("short sdo", 64'hc33c0, asfc_host_model_i.rx);
    tick(5);
    cmp_word("short cmd", c, n_cmd);
    wait_ready();
    asfc_host_model_i.frame(64, 64'hdead_beef_0f0f_0f0f);
    cmp_word("chain", 64'hc33c_0000_dead_beef, asfc_host_model_i.rx);
    tick(5);
    cmp_word("long cmd", 32'h0f0f_0f0f, last_cmd);
    wait_ready();
    $display("test short and long frames done");
  endtask

  task automatic t_standby();
    int c;
    c = n_cmd;
    asfc_host_model_i.frame(32, {32'h0, CMD_STANDBY, 16'h0});
    tick(5);
    cmp_state("standby", ST_STANDBY, state);
    asfc_host_model_i.frame(32, 64'h0);
    cmp_word("invalid", {32'h0, INVALID_WORD}, asfc_host_model_i.rx);
    tick(5);
    cmp_state("stay", ST_STANDBY, state);
    asfc_host_model_i.frame(16, 64'h0);
    tick(5);
    cmp_word("write", c + 3, n_cmd);
    cmp_word("write word", 0, last_cmd);
    asfc_host_model_i.frame(32, 64'h1);
    tick(5);
    cmp_state("leave", ST_CONV, state);
    wait_ready();
    $display("test standby done");
  endtask

  task automatic t_pin(input logic sel, input int cyc);
    int k;
    int a;
    int p;
    a = n_app;
    p = n_por;
    k = 0;
    app_sel = sel;
    asfc_host_model_i.set_rst(1'b0);
    tick(6);
    cmp_state("reset", ST_RESET, state);
    cmp_word("ready low", 0, ready);
    cmp_word("oe off", 0, oe);
    cmp_word("app pulse", a + sel, n_app);
    cmp_word("por pulse", p + !sel, n_por);
    asfc_host_model_i.set_rst(1'b1);
    while (ready !== 1'b1 && k < cyc + 20) begin
      tick(1);
      k++;
    end
    cmp_word("delay", 1, k >= cyc && k <= cyc + 4);
    cmp_state("acq", ST_ACQ, state);
    $display("test reset pin done");
  endtask

  task automatic t_nap();
    nap_en = 1'b1;
    tick(4);
    cmp_word("nap", 1, low_power_nap);
    fork
      asfc_host_model_i.frame(32, 64'h0);
      begin
        tick(10);
        cmp_word("frame nap", 0, low_power_nap);
        cmp_word("frame ready", 0, ready);
      end
    join
    nap_en = 1'b0;
    tick(5);
    wait_ready();
    $display("test nap done");
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    rst_in = 1'b1;
    app_sel = 1'b0;
    nap_en = 1'b0;
    result = 16'h0;
    tick(2);
    cmp_word("reset ready", 1, ready);
    cmp_state("reset state", ST_ACQ, state);
    rst_in = 1'b0;
    tick(4);
    t_full();
    t_short_long();
    t_standby();
    t_pin(1'b1, APP_CYC);
    t_pin(1'b0, POR_CYC);
    t_nap();
    finish_test();
  end
endmodule
